// [pkg/alert_pkg.sv]
package alert_pkg;

    // ------------------------------------------------------------
    // timing counts
    // ------------------------------------------------------------
    // cycles the overflow low pulse is held on the shared line
    localparam logic [15:0] ALERT_HOLD_CYCLES = 16'h0010;
    // cycles after release before the line is trusted again
    // (covers the three-stage pin synchroniser)
    localparam logic [3:0]  SETTLE_CYCLES     = 4'h4;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic LINE_IDLE_LEVEL   = 1'b1;
    localparam logic LINK_STATUS_RESET = 1'b1;
    localparam logic PIPE_MODE_N_RESET = 1'b1;

    // ------------------------------------------------------------
    // controller states, one-hot
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_IDLE   = 4'b0001,
        ST_ALERT  = 4'b0010,
        ST_SETTLE = 4'b0100,
        ST_SLEEP  = 4'b1000
    } line_state_e;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    // overflow report from the serial buffers
    typedef struct packed {
        logic buffer_overflow; // one-cycle pulse
        logic host_sending;    // host is transmitting serial data
    } ovf_event_s;

    // link state from the radio side
    typedef struct packed {
        logic peer_connected;
        logic pipe_ready;
    } link_info_s;

    // power control toward processor and radio
    typedef struct packed {
        logic cpu_run;
        logic radio_run;
        logic halt_pulse;
        logic close_link_pulse;
    } power_ctl_s;

endpackage

// [verilog/pin_sync.sv]
`timescale 1ns/1ps

module pin_sync #(
    parameter logic INIT = 1'b1
) (
    input  wire logic core_clk,
    input  wire logic reset,
    input  wire logic pin_async,
    output logic      pin_level
);

    logic stage1_reg;
    logic stage2_reg;
    logic stage3_reg;

    // ------------------------------------------------------------
    // three flops, level follows once stages two and three agree
    // ------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            stage1_reg <= INIT;
            stage2_reg <= INIT;
            stage3_reg <= INIT;
        end
        else
        begin
            stage1_reg <= pin_async;
            stage2_reg <= stage1_reg;
            stage3_reg <= stage2_reg;
        end
    end

    // accepted level
    always_ff @(posedge core_clk)
    begin
        if (reset)
            pin_level <= INIT;
        else if (stage2_reg == stage3_reg)
            pin_level <= stage3_reg;
    end

endmodule

// [verilog/overflow_alert_shutdown_pin.sv]
`timescale 1ns/1ps

// Summary of operation
// - shared line: open drain, active low, idles high
// - host pull from idle: halt, close link, hibernate
// - hibernation keeps processor and radio fully off
// - line held high permits processor and radio
// - device pulls only from idle, only on overflow
// - overflow while host sends means receive overflow
// - overflow while host idle means transmit overflow
// - no overflow means line stays released
// - after boot line is released high
// - link status output is active low
// - mode input: low selects pipe mode, high selects command mode
// - command mode: low while peer connected
// - pipe mode: low when stream connected and ready
module overflow_alert_shutdown_pin #(
    parameter logic [15:0] HOLD_CYCLES = alert_pkg::ALERT_HOLD_CYCLES
) (
    input  wire logic                   core_clk,
    input  wire logic                   reset,
    input  wire logic                   alert_and_sleep_line_in,
    output logic                        alert_and_sleep_line_out,
    output logic                        alert_and_sleep_line_oe,
    input  wire logic                   serial_pipe_mode_n,
    input  wire alert_pkg::ovf_event_s  ovf_event,
    input  wire alert_pkg::link_info_s  link_info,
    output alert_pkg::power_ctl_s       power_ctl,
    output logic                        overflow_kind_rx,
    output logic                        link_status_n
);

    alert_pkg::line_state_e state_reg;
    alert_pkg::line_state_e state_next;

    logic        line_level;
    logic        pipe_mode_n_level;
    logic        line_idle;
    logic        host_pull;
    logic        ovf_pending_reg;
    logic        alert_start;
    logic [15:0] hold_cnt_reg;
    logic [3:0]  settle_cnt_reg;
    logic        hold_done;
    logic        settle_done;
    logic        kind_rx_reg;
    logic        pend_rx_reg;
    logic        start_rx;
    logic        halt_reg;
    logic        run_reg;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    pin_sync #(
        .INIT      (alert_pkg::LINE_IDLE_LEVEL)
    ) u_line_sync (
        .core_clk  (core_clk),
        .reset     (reset),
        .pin_async (alert_and_sleep_line_in),
        .pin_level (line_level)
    );

    pin_sync #(
        .INIT      (alert_pkg::PIPE_MODE_N_RESET)
    ) u_mode_sync (
        .core_clk  (core_clk),
        .reset     (reset),
        .pin_async (serial_pipe_mode_n),
        .pin_level (pipe_mode_n_level)
    );

    // ------------------------------------------------------------
    // line decode
    // ------------------------------------------------------------
    // idle: released by us and seen high
    assign line_idle   = line_level && (state_reg == alert_pkg::ST_IDLE);
    // low seen in idle, where we are not driving, is the host's pull
    assign host_pull   = !line_level && (state_reg == alert_pkg::ST_IDLE);
    // start an alert only from the idle high line
    assign alert_start = line_idle
                      && (ovf_event.buffer_overflow || ovf_pending_reg);
    assign hold_done   = hold_cnt_reg == HOLD_CYCLES - 16'h0001;
    assign settle_done = settle_cnt_reg == alert_pkg::SETTLE_CYCLES - 4'h1;
    // kind of the overflow being started: a fresh event or the held one
    assign start_rx    = ovf_event.buffer_overflow ? ovf_event.host_sending
                                                   : pend_rx_reg;

    // ------------------------------------------------------------
    // state machine
    // ------------------------------------------------------------
    // next state
    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            alert_pkg::ST_IDLE:
            begin
                if (host_pull)
                    state_next = alert_pkg::ST_SLEEP;
                else if (alert_start)
                    state_next = alert_pkg::ST_ALERT;
            end
            alert_pkg::ST_ALERT:
            begin
                if (hold_done)
                    state_next = alert_pkg::ST_SETTLE;
            end
            alert_pkg::ST_SETTLE:
            begin
                if (settle_done)
                    state_next = alert_pkg::ST_IDLE;
            end
            alert_pkg::ST_SLEEP:
            begin
                if (line_level)
                    state_next = alert_pkg::ST_IDLE;
            end
        endcase
    end

    // state register
    always_ff @(posedge core_clk)
    begin
        if (reset)
            state_reg <= alert_pkg::ST_IDLE;
        else
            state_reg <= state_next;
    end

    // ------------------------------------------------------------
    // overflow capture
    // ------------------------------------------------------------
    // pending overflow; a new event wins over the sleep clear, not over an alert start
    always_ff @(posedge core_clk)
    begin
        if (reset)
            ovf_pending_reg <= 1'b0;
        else if (ovf_event.buffer_overflow && !alert_start)
            ovf_pending_reg <= 1'b1;
        else if (alert_start || state_next == alert_pkg::ST_SLEEP)
            ovf_pending_reg <= 1'b0;
    end

    // which buffer lost data, fixed at alert start
    always_ff @(posedge core_clk)
    begin
        if (reset)
            kind_rx_reg <= 1'b0;
        else if (alert_start && !host_pull)
            kind_rx_reg <= start_rx;
    end

    // direction of a held overflow, taken when it happened, so a late
    // start still reports the buffer that really lost data
    always_ff @(posedge core_clk)
    begin
        if (reset)
            pend_rx_reg <= 1'b0;
        else if (ovf_event.buffer_overflow && !alert_start)
            pend_rx_reg <= ovf_event.host_sending;
    end

    // ------------------------------------------------------------
    // counters
    // ------------------------------------------------------------
    // low hold length
    always_ff @(posedge core_clk)
    begin
        if (reset)
            hold_cnt_reg <= 16'h0000;
        else if (state_reg == alert_pkg::ST_ALERT && !hold_done)
            hold_cnt_reg <= hold_cnt_reg + 16'h0001;
        else
            hold_cnt_reg <= 16'h0000;
    end

    // wait for the released line to pass the synchroniser
    always_ff @(posedge core_clk)
    begin
        if (reset)
            settle_cnt_reg <= 4'h0;
        else if (state_reg == alert_pkg::ST_SETTLE && !settle_done)
            settle_cnt_reg <= settle_cnt_reg + 4'h1;
        else
            settle_cnt_reg <= 4'h0;
    end

    // ------------------------------------------------------------
    // power control
    // ------------------------------------------------------------
    // halt and close pulse on entry to hibernation
    always_ff @(posedge core_clk)
    begin
        if (reset)
            halt_reg <= 1'b0;
        else
            halt_reg <= (state_reg == alert_pkg::ST_IDLE)
                     && (state_next == alert_pkg::ST_SLEEP);
    end

    // run permission, dropped at once on the pull
    always_ff @(posedge core_clk)
    begin
        if (reset)
            run_reg <= 1'b1;
        else
            run_reg <= state_next != alert_pkg::ST_SLEEP;
    end

    assign power_ctl.cpu_run          = run_reg;
    assign power_ctl.radio_run        = run_reg;
    assign power_ctl.halt_pulse       = halt_reg;
    assign power_ctl.close_link_pulse = halt_reg;

    // ------------------------------------------------------------
    // line drive
    // ------------------------------------------------------------
    // only ever pull low, enable only during alert
    assign alert_and_sleep_line_out = 1'b0;
    assign alert_and_sleep_line_oe  =
        state_reg == alert_pkg::ST_ALERT;
    assign overflow_kind_rx         = kind_rx_reg;

    // ------------------------------------------------------------
    // link status
    // ------------------------------------------------------------
    // active low, meaning set by pipe mode
    always_ff @(posedge core_clk)
    begin
        if (reset)
            link_status_n <= alert_pkg::LINK_STATUS_RESET;
        else if (!pipe_mode_n_level)
            link_status_n <= !(link_info.peer_connected
                            && link_info.pipe_ready);
        else
            link_status_n <= !link_info.peer_connected;
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);

    chk_line_low_only: assert property (
        alert_and_sleep_line_out == 1'b0)
        else $error("line driven to a high level");

    chk_pull_to_sleep: assert property (
        (state_reg == alert_pkg::ST_IDLE && !line_level)
        |=> state_reg == alert_pkg::ST_SLEEP
            && power_ctl.halt_pulse && power_ctl.close_link_pulse)
        else $error("host pull did not halt and sleep");

    chk_sleep_quiet: assert property (
        state_reg == alert_pkg::ST_SLEEP
        |-> !power_ctl.cpu_run && !power_ctl.radio_run)
        else $error("activity during hibernation");

    chk_awake_runs: assert property (
        (state_reg == alert_pkg::ST_SLEEP && line_level)
        |=> ##1 power_ctl.cpu_run && power_ctl.radio_run)
        else $error("activity not restored after release");

    chk_pull_from_idle: assert property (
        $rose(alert_and_sleep_line_oe)
        |-> $past(line_level) && $past(state_reg == alert_pkg::ST_IDLE))
        else $error("alert started on a busy line");

    chk_kind_rx: assert property (
        (alert_start && !host_pull
         && (ovf_event.buffer_overflow ? ovf_event.host_sending
                                       : pend_rx_reg))
        |=> overflow_kind_rx && alert_and_sleep_line_oe)
        else $error("receive overflow not reported");

    chk_kind_tx: assert property (
        (alert_start && !host_pull
         && !(ovf_event.buffer_overflow ? ovf_event.host_sending
                                        : pend_rx_reg))
        |=> !overflow_kind_rx && alert_and_sleep_line_oe)
        else $error("transmit overflow not reported");

    chk_no_ovf_quiet: assert property (
        $rose(alert_and_sleep_line_oe)
        |-> $past(ovf_event.buffer_overflow) || $past(ovf_pending_reg))
        else $error("line pulled without an overflow");

    chk_boot_high: assert property (
        $past(reset) |-> !alert_and_sleep_line_oe && link_status_n
                         && power_ctl.cpu_run)
        else $error("bad state after boot");

    chk_link_cmd: assert property (
        pipe_mode_n_level |=> link_status_n == !$past(link_info.peer_connected))
        else $error("command mode link status wrong");

    chk_link_pipe: assert property (
        !pipe_mode_n_level
        |=> link_status_n == !($past(link_info.peer_connected)
                               && $past(link_info.pipe_ready)))
        else $error("pipe mode link status wrong");

    chk_hold_len: assert property (
        $fell(alert_and_sleep_line_oe)
        |-> $past(hold_cnt_reg) == HOLD_CYCLES - 16'h0001)
        else $error("alert hold length wrong");

    cov_alert: cover property ($rose(alert_and_sleep_line_oe));
    cov_sleep: cover property (power_ctl.halt_pulse);
    cov_wake: cover property (
        state_reg == alert_pkg::ST_SLEEP ##1 state_reg == alert_pkg::ST_IDLE);
    cov_pipe_ready: cover property (!pipe_mode_n_level && !link_status_n);
    cov_merged: cover property (
        ovf_event.buffer_overflow && state_reg == alert_pkg::ST_ALERT);

endmodule

// [sim/host_model.sv]
`timescale 1ns/1ps

// ------------------------------------------------------------
// host side of the shared open-drain line
// ------------------------------------------------------------
module host_model (
    input  wire logic device_out,
    input  wire logic device_oe,
    input  wire logic host_pull,
    output logic      line_level
);
    // wired-and with pull-up: any puller wins, idle high
    assign line_level = ((device_oe && !device_out) || host_pull)
                        ? 1'b0 : 1'b1;
endmodule

// [sim/tb.sv]
`timescale 1ns/1ps

module tb;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    localparam logic [15:0] HOLD = 16'h0004;
    logic                  core_clk;
    logic                  reset;
    logic                  host_pull;
    logic                  line_level;
    logic                  line_out;
    logic                  line_oe;
    logic                  serial_pipe_mode_n;
    alert_pkg::ovf_event_s ovf_event;
    alert_pkg::link_info_s link_info;
    alert_pkg::power_ctl_s power_ctl;
    logic                  overflow_kind_rx;
    logic                  link_status_n;
    int                    mismatches;
    int                    tests_run;

    overflow_alert_shutdown_pin #(.HOLD_CYCLES(HOLD))
        overflow_alert_shutdown_pin_inst (
        .core_clk                (core_clk),
        .reset                   (reset),
        .alert_and_sleep_line_in (line_level),
        .alert_and_sleep_line_out(line_out),
        .alert_and_sleep_line_oe (line_oe),
        .serial_pipe_mode_n      (serial_pipe_mode_n),
        .ovf_event               (ovf_event),
        .link_info               (link_info),
        .power_ctl               (power_ctl),
        .overflow_kind_rx        (overflow_kind_rx),
        .link_status_n           (link_status_n)
    );

    host_model host_model_inst (
        .device_out(line_out),
        .device_oe (line_oe),
        .host_pull (host_pull),
        .line_level(line_level)
    );

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // free-running 100 MHz clock
    initial
    begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // step n cycles, land just after the last edge
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic finish_test();
        $display("mismatches=%0d tests_run=%0d", mismatches, tests_run);
        if (mismatches == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic timed_out();
        mismatches++;
        $display("[FAIL] t=%0t wait bound used up", $time);
        finish_test();
    endtask

    // one overflow pulse on the event input
    task automatic pulse_overflow(input logic sending);
        ovf_event.host_sending    = sending;
        ovf_event.buffer_overflow = 1'b1;
        tick(1);
        ovf_event = '0; // host goes quiet after the event
    endtask

    // wait for the pull to start, then count its length
    task automatic measure_alert(output int cnt);
        int w;
        w = 0;
        while (line_oe !== 1'b1)
        begin
            if (w++ > 12)
                timed_out();
            tick(1);
        end
        check(line_level, 1'b0);
        cnt = 0;
        while (line_oe === 1'b1 && cnt < 100)
        begin
            cnt++;
            tick(1);
        end
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    // released line after boot and while nothing overflows
    task automatic test_boot();
        check(power_ctl.cpu_run, 1'b1);
        check(power_ctl.radio_run, 1'b1);
        check(link_status_n, 1'b1);
        repeat (20)
        begin
            check(line_oe, 1'b0);
            check(line_level, 1'b1);
            tick(1);
        end
        $display("test boot done");
    endtask

    // single overflow, kind from host direction, fixed hold
    task automatic test_overflow(input logic sending);
        int cnt;
        pulse_overflow(sending);
        measure_alert(cnt);
        check(overflow_kind_rx, sending);
        check(cnt, HOLD);
        tick(8);
        check(line_oe, 1'b0);
        $display("test overflow sending=%0d done", sending);
    endtask

    // second overflow during an alert gives a second full alert
    task automatic test_merged();
        int cnt;
        pulse_overflow(1'b0);
        tick(1);
        pulse_overflow(1'b1);
        measure_alert(cnt);
        // two cycles of the first alert passed before counting began
        check(cnt + 2, HOLD);
        check(overflow_kind_rx, 1'b0);
        measure_alert(cnt);
        check(cnt, HOLD);
        check(overflow_kind_rx, 1'b1);
        tick(8);
        $display("test merged done");
    endtask

    // host forces hibernation, overflow then stays silent
    task automatic test_sleep();
        int   w;
        logic seen;
        host_pull = 1'b1;
        w = 0;
        while (power_ctl.cpu_run !== 1'b0)
        begin
            if (w++ > 10)
                timed_out();
            tick(1);
        end
        check(power_ctl.radio_run, 1'b0);
        seen = 1'b0;
        repeat (4)
        begin
            if (power_ctl.halt_pulse === 1'b1
                && power_ctl.close_link_pulse === 1'b1)
                seen = 1'b1;
            tick(1);
        end
        check(seen, 1'b1);
        pulse_overflow(1'b1);
        repeat (10)
        begin
            check(line_oe, 1'b0);
            check({power_ctl.cpu_run, power_ctl.radio_run}, 2'b00);
            tick(1);
        end
        host_pull = 1'b0;
        w = 0;
        while (power_ctl.cpu_run !== 1'b1)
        begin
            if (w++ > 10)
                timed_out();
            tick(1);
        end
        check(power_ctl.radio_run, 1'b1);
        tick(8);
        check(line_oe, 1'b0);
        $display("test sleep done");
    endtask

    // status output in both modes over all link states
    task automatic test_link();
        logic exp;
        for (int m = 0; m < 2; m++)
        begin
            serial_pipe_mode_n = m[0];
            tick(6);
            for (int k = 0; k < 4; k++)
            begin
                link_info = k[1:0];
                tick(2);
                exp = m[0] ? !k[1] : !(k[1] && k[0]);
                check(link_status_n, exp);
            end
        end
        $display("test link done");
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        mismatches         = 0;
        tests_run          = 0;
        reset              = 1'b1;
        host_pull          = 1'b0;
        serial_pipe_mode_n = 1'b1;
        ovf_event          = '0;
        link_info          = '0;
        tick(4);
        reset = 1'b0;
        tick(1);
        test_boot();
        test_overflow(1'b1);
        test_overflow(1'b0);
        test_merged();
        test_sleep();
        test_link();
        finish_test();
    end
endmodule
